// ===== rtl/idis_top.sv
// dma handshake gating and isa interrupt steering with its apb registers
module idis_top
	import idis_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// isa bus side
	input  idis_isa_t        isa_i,
	input  wire logic        floppy_dma_ack_n_i,
	input  wire logic        parport_dma_ack_n_i,
	output idis_pin_t        zero_wait_n_o,
	// requests and sources from the function units
	input  wire logic        fdc_req_i,
	input  wire logic        par_req_i,
	input  wire logic [3:0]  ser0_pend_i,
	input  wire logic [3:0]  ser1_pend_i,
	input  wire logic        par_int_i,
	// dma pins
	output idis_pin_t        floppy_dma_req_o,
	output idis_pin_t        parport_dma_req_o,
	// dma strobes to the function units
	output idis_dma_t        floppy_dma_o,
	output idis_dma_t        parport_dma_o,
	// interrupt pins
	output idis_pin_t        irq3_o,
	output idis_pin_t        irq4_o,
	output idis_pin_t        irq5_o,
	output idis_pin_t        irq7_o
);

	// ****************************************************************
	// apb slave
	// ****************************************************************
	logic [31:0] dma_ctrl_q;
	logic [31:0] irq_cfg_q;
	logic [31:0] ser_ctrl_q;
	logic        acc;
	logic        wr_en;
	logic        mapped;
	logic [31:0] rd_d;
	logic [31:0] bmask;

	assign acc   = psel_i & penable_i;
	assign wr_en = acc & pready_o & pwrite_i & mapped;

	// byte enables widened to a bit mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			bmask[i*8 +: 8] = {8{pstrb_i[i]}};
		end
	end

	// address decode and read mux
	always_comb begin
		mapped = 1'b1;
		rd_d   = 32'h0000_0000;
		unique case (paddr_i)
			ADDR_DMA_CTRL: rd_d = dma_ctrl_q;
			ADDR_IRQ_CFG:  rd_d = irq_cfg_q;
			ADDR_SER_CTRL: rd_d = ser_ctrl_q;
			ADDR_STATUS: begin
				rd_d = {20'h0_0000,
					irq7_o, irq5_o, irq4_o, irq3_o,
					parport_dma_req_o, floppy_dma_req_o};
			end
			default: mapped = 1'b0;
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else if (ce_i) begin
			pready_o  <= acc & ~pready_o;
			pslverr_o <= acc & ~pready_o & ~mapped;
			prdata_o  <= (acc & ~pready_o & ~pwrite_i) ? rd_d : 32'h0000_0000;
		end
	end

	// control registers, written at the completing edge only
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dma_ctrl_q <= DMA_CTRL_RST;
			irq_cfg_q  <= IRQ_CFG_RST;
			ser_ctrl_q <= SER_CTRL_RST;
		end else if (ce_i && wr_en) begin
			if (paddr_i == ADDR_DMA_CTRL) begin
				dma_ctrl_q <= ((dma_ctrl_q & ~bmask) | (pwdata_i & bmask))
					& ((32'h1 << FL_GATE_BIT) | (32'h1 << PP_GATE_BIT)
					| (32'h1 << ECP_HW_BIT));
			end
			if (paddr_i == ADDR_IRQ_CFG) begin
				irq_cfg_q <= ((irq_cfg_q & ~bmask) | (pwdata_i & bmask))
					& IRQ_CFG_MASK;
			end
			if (paddr_i == ADDR_SER_CTRL) begin
				ser_ctrl_q <= ((ser_ctrl_q & ~bmask) | (pwdata_i & bmask))
					& SER_MASK;
			end
		end
	end

	// ****************************************************************
	// register fields
	// ****************************************************************
	logic       fl_gate;
	logic       pp_gate;
	logic       ecp_hw;
	logic       sw_cfg;
	logic [1:0] ser0_base;
	logic [1:0] ser1_base;
	logic [1:0] par_base;
	logic [3:0] ena0;
	logic [3:0] ena1;
	logic       ser0_gate;
	logic       ser1_gate;

	assign fl_gate   = dma_ctrl_q[FL_GATE_BIT];
	assign pp_gate   = dma_ctrl_q[PP_GATE_BIT];
	assign ecp_hw    = dma_ctrl_q[ECP_HW_BIT];
	assign sw_cfg    = irq_cfg_q[SW_CFG_BIT];
	assign ser0_base = irq_cfg_q[SER0_BASE_LSB +: 2];
	assign ser1_base = irq_cfg_q[SER1_BASE_LSB +: 2];
	assign par_base  = irq_cfg_q[PAR_BASE_LSB +: 2];
	assign ena0      = ser_ctrl_q[SER0_ENA_LSB +: SER_ENA_W];
	assign ena1      = ser_ctrl_q[SER1_ENA_LSB +: SER_ENA_W];
	assign ser0_gate = ser_ctrl_q[SER0_GATE_BIT];
	assign ser1_gate = ser_ctrl_q[SER1_GATE_BIT];

	// ****************************************************************
	// dma handshake
	// ****************************************************************
	logic fl_ack;
	logic pp_ack;
	logic fl_cyc;
	logic pp_cyc;
	logic any_cyc;

	// acks count only with their gate bit and address enable
	assign fl_ack  = ~floppy_dma_ack_n_i & fl_gate;           // R05
	assign pp_ack  = ~parport_dma_ack_n_i & ecp_hw & pp_gate; // R08
	assign fl_cyc  = isa_i.aen & fl_ack;                      // R19
	assign pp_cyc  = isa_i.aen & pp_ack;                      // R19
	assign any_cyc = isa_i.aen & (fl_ack | pp_ack);

	// request pins: floppy floats when gated off
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			floppy_dma_req_o <= '0;
		end else if (ce_i) begin
			floppy_dma_req_o.lvl <= fdc_req_i & fl_gate; // R01
			floppy_dma_req_o.oe  <= fl_gate;             // R02
		end
	end

	// parport request: negated outside ecp hw mode, floats when gated
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			parport_dma_req_o <= '0;
		end else if (ce_i) begin
			parport_dma_req_o.lvl <= par_req_i & ecp_hw & pp_gate; // R06 R07
			parport_dma_req_o.oe  <= ~ecp_hw | pp_gate;            // R07
		end
	end

	// strobes and terminal count handed to the function units
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			floppy_dma_o  <= '0;
			parport_dma_o <= '0;
		end else if (ce_i) begin
			floppy_dma_o.rd  <= fl_cyc & ~isa_i.iorc_n;  // R04
			floppy_dma_o.wr  <= fl_cyc & ~isa_i.iowc_n;  // R04
			floppy_dma_o.tc  <= fl_cyc & isa_i.tc;       // R10
			parport_dma_o.rd <= pp_cyc & ~isa_i.iorc_n;  // R08
			parport_dma_o.wr <= pp_cyc & ~isa_i.iowc_n;  // R08
			parport_dma_o.tc <= pp_cyc & isa_i.tc;       // R10
		end
	end

	// zero wait: open drain, pulled low for plain decoded i/o only
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			zero_wait_n_o <= '0;
		end else if (ce_i) begin
			zero_wait_n_o.lvl <= 1'b0;
			zero_wait_n_o.oe  <= isa_i.hit & ~isa_i.ide_hit & ~isa_i.aen
				& ~any_cyc & (~isa_i.iorc_n | ~isa_i.iowc_n); // R20
		end
	end

	// ****************************************************************
	// serial interrupt steering
	// ****************************************************************
	logic ser0_on4;
	logic ser1_on4;
	logic ser0_act;
	logic ser1_act;
	logic en3;
	logic en4;
	logic act3;
	logic act4;

	// hardware config follows the base, software config a free select
	always_comb begin
		ser0_on4 = (ser0_base == SER_BASE_3F8) || (ser0_base == SER_BASE_3E8);
		ser1_on4 = (ser1_base == SER_BASE_3F8) || (ser1_base == SER_BASE_3E8);
		if (sw_cfg) begin
			ser0_on4 = irq_cfg_q[SER0_SEL4_BIT]; // R13
			ser1_on4 = irq_cfg_q[SER1_SEL4_BIT]; // R13
		end
	end

	// global gate from modem control, conditions from int enable
	assign ser0_act = ser0_gate & |(ser0_pend_i & ena0); // R14
	assign ser1_act = ser1_gate & |(ser1_pend_i & ena1); // R14
	assign en3  = (ser0_gate & ~ser0_on4) | (ser1_gate & ~ser1_on4); // R12 R15
	assign en4  = (ser0_gate & ser0_on4) | (ser1_gate & ser1_on4);   // R12 R15
	assign act3 = (ser0_act & ~ser0_on4) | (ser1_act & ~ser1_on4);
	assign act4 = (ser0_act & ser0_on4) | (ser1_act & ser1_on4);

	// ****************************************************************
	// parallel interrupt steering
	// ****************************************************************
	logic par_on7;
	logic par_en;

	// 278h base gives irq5, 378h or 3bch irq7
	assign par_on7 = sw_cfg ? irq_cfg_q[PAR_SEL7_BIT]
		: (par_base != PAR_BASE_278); // R18
	assign par_en  = irq_cfg_q[PAR_EN_BIT];

	// ****************************************************************
	// pin drivers
	// ****************************************************************
	idis_irq_drv u_irq3 (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.en_i       (en3),
		.act_i      (act3),
		.pol_high_i (irq_cfg_q[POL_IRQ3_BIT]), // R11
		.pin_o      (irq3_o)
	);

	idis_irq_drv u_irq4 (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.en_i       (en4),
		.act_i      (act4),
		.pol_high_i (irq_cfg_q[POL_IRQ4_BIT]), // R11
		.pin_o      (irq4_o)
	);

	idis_irq_drv u_irq5 (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.en_i       (par_en & ~par_on7), // R17
		.act_i      (par_int_i),
		.pol_high_i (irq_cfg_q[POL_IRQ5_BIT]), // R16
		.pin_o      (irq5_o)
	);

	idis_irq_drv u_irq7 (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.en_i       (par_en & par_on7), // R17
		.act_i      (par_int_i),
		.pol_high_i (irq_cfg_q[POL_IRQ7_BIT]), // R16
		.pin_o      (irq7_o)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_fl_ungated;
		ce_i && !fl_gate;
	endsequence

	a_floppy_req_gate: assert property ( // R01
		floppy_dma_req_o.lvl |-> $past(fl_gate) && $past(fdc_req_i))
		else $error("floppy request without gate");

	a_floppy_req_float: assert property ( // R02
		s_fl_ungated |=> !floppy_dma_req_o.oe)
		else $error("floppy request driven while disabled");

	a_floppy_ack_gate: assert property ( // R05
		ce_i && !fl_gate |=> !floppy_dma_o.rd && !floppy_dma_o.wr
			&& !floppy_dma_o.tc)
		else $error("floppy ack honoured while disabled");

	a_floppy_strobe: assert property ( // R04
		ce_i && fl_cyc && !isa_i.iorc_n |=> floppy_dma_o.rd)
		else $error("floppy read strobe missed");

	a_parport_neg: assert property ( // R06
		ce_i && !ecp_hw |=> parport_dma_req_o.oe && !parport_dma_req_o.lvl)
		else $error("parport request outside ecp hw mode");

	a_parport_float: assert property ( // R07
		ce_i && ecp_hw && !pp_gate |=> !parport_dma_req_o.oe)
		else $error("parport request driven while gated");

	a_parport_strobe: assert property ( // R08
		parport_dma_o.wr |-> $past(pp_cyc) && !$past(isa_i.iowc_n))
		else $error("parport write strobe without ack");

	a_tc_needs_ack: assert property ( // R10
		floppy_dma_o.tc || parport_dma_o.tc |-> $past(isa_i.tc)
			&& $past(isa_i.aen) && ($past(fl_ack) || $past(pp_ack)))
		else $error("terminal count taken without ack");

	a_dma_cycle_aen: assert property ( // R19
		floppy_dma_o.rd || parport_dma_o.rd |-> $past(isa_i.aen))
		else $error("dma strobe without address enable");

	a_no_zws_dma: assert property ( // R20
		zero_wait_n_o.oe |-> !$past(any_cyc) && !$past(isa_i.aen))
		else $error("zero wait asserted in dma cycle");

	a_ser_float: assert property ( // R15
		ce_i && !ser0_gate && !ser1_gate |=> !irq3_o.oe && !irq4_o.oe)
		else $error("serial irq driven while disabled");

	a_irq3_hw_route: assert property ( // R12
		ce_i && !sw_cfg && ser0_gate && !ser1_gate
			&& ser0_base == SER_BASE_2F8 |=> irq3_o.oe && !irq4_o.oe)
		else $error("serial irq misrouted");

	a_par_one_line: assert property ( // R17
		!(irq5_o.oe && irq7_o.oe))
		else $error("parport irq on two lines");

	a_par_hw_route: assert property ( // R18
		ce_i && !sw_cfg && par_en && par_base == PAR_BASE_278
			|=> irq5_o.oe && !irq7_o.oe)
		else $error("parport irq misrouted");

	a_irq_polarity: assert property ( // R16
		ce_i && !irq_cfg_q[POL_IRQ5_BIT] && !par_int_i |=> irq5_o.lvl)
		else $error("active low idle level wrong");

	a_apb_wait: assert property (
		ce_i && psel_i && penable_i && !pready_o |=> pready_o)
		else $error("apb answer late");

endmodule

// ===== rtl/idis_pkg.sv
// constants, field layouts and carrier types of the dma and irq steering block
//
// What this block and the system dma controller do
// (R01) floppy dma request is driven only while digital_output_reg bit 3 enables dma
// (R02) floppy dma request output floats whenever floppy dma is disabled
// (R03) system dma controller acknowledges a floppy request with floppy_dma_ack_n low
// (R04) with floppy ack asserted, isa read/write strobes become floppy dma strobes
// (R05) floppy ack is ignored unless digital_output_reg bit 3 enables floppy dma
// (R06) parport dma request used only in ecp hardware mode, negated otherwise
// (R07) in ecp hardware mode, extended_control_reg bit 3 gates request, else floats
// (R08) parport ack plus extended_control_reg bit 3 turns strobes into dma strobes
// (R09) system dma controller raises terminal count during its last transfer
// (R10) terminal count honoured only while a dma acknowledge is asserted
// (R11) irq3 and irq4 polarity chosen high or low through chip_config2
// (R12) hardware config: 2f8/2e8 serial base uses irq3, 3f8/3e8 uses irq4
// (R13) software config: serial irq lines assigned freely, no base tracking
// (R14) serial line enabled by modem_control_reg bit 3, asserted per int_enable_reg
// (R15) a serial irq line that is not enabled floats
// (R16) irq5 and irq7 polarity chosen high or low through chip_config2
// (R17) parport irq drives only irq5 or irq7 per parport_config1, other floats
// (R18) hardware config: parport at 278h uses irq5, at 3bch or 378h irq7
// (R19) a dma cycle needs address enable together with a dma acknowledge
// (R20) the zero wait state output is never asserted during dma accesses
package idis_pkg;

	// ****************************************************************
	// register map, byte addresses on the apb
	// ****************************************************************
	localparam logic [11:0] ADDR_DMA_CTRL = 12'h000;
	localparam logic [11:0] ADDR_IRQ_CFG  = 12'h004;
	localparam logic [11:0] ADDR_SER_CTRL = 12'h008;
	localparam logic [11:0] ADDR_STATUS   = 12'h00C;

	// dma control fields
	localparam int FL_GATE_BIT   = 3;   // digital_output_reg dma gate
	localparam int PP_GATE_BIT   = 11;  // extended_control_reg bit 3, byte 1
	localparam int ECP_HW_BIT    = 16;  // parallel port in ecp hardware mode

	// irq configuration fields (chip_config2 and parport_config1)
	localparam int POL_IRQ3_BIT  = 0;
	localparam int POL_IRQ4_BIT  = 1;
	localparam int POL_IRQ5_BIT  = 2;
	localparam int POL_IRQ7_BIT  = 3;
	localparam int SW_CFG_BIT    = 4;
	localparam int PAR_EN_BIT    = 5;
	localparam int PAR_SEL7_BIT  = 6;
	localparam int SER0_SEL4_BIT = 7;
	localparam int SER1_SEL4_BIT = 8;
	localparam int SER0_BASE_LSB = 9;
	localparam int SER1_BASE_LSB = 11;
	localparam int PAR_BASE_LSB  = 13;

	// serial control: enable nibble then modem control byte per port
	localparam int SER0_ENA_LSB  = 0;
	localparam int SER0_GATE_BIT = 11;  // modem_control_reg bit 3, port 0
	localparam int SER1_ENA_LSB  = 16;
	localparam int SER1_GATE_BIT = 27;  // modem_control_reg bit 3, port 1
	localparam int SER_ENA_W     = 4;

	// reset values: polarities active high, everything else off
	localparam logic [31:0] DMA_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] IRQ_CFG_RST  = 32'h0000_000F;
	localparam logic [31:0] SER_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] IRQ_CFG_MASK = 32'h0000_7FFF;
	localparam logic [31:0] SER_MASK     = 32'h080F_080F;

	// serial base codes
	localparam logic [1:0] SER_BASE_3F8 = 2'h0;
	localparam logic [1:0] SER_BASE_2F8 = 2'h1;
	localparam logic [1:0] SER_BASE_3E8 = 2'h2;
	localparam logic [1:0] SER_BASE_2E8 = 2'h3;

	// parallel base codes
	localparam logic [1:0] PAR_BASE_378 = 2'h0;
	localparam logic [1:0] PAR_BASE_278 = 2'h1;
	localparam logic [1:0] PAR_BASE_3BC = 2'h2;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic aen;       // address enable, high in dma cycles
		logic iorc_n;    // read command strobe
		logic iowc_n;    // write command strobe
		logic tc;        // terminal count
		logic hit;       // valid internal address decoded
		logic ide_hit;   // decoded access belongs to the ide interface
	} idis_isa_t;

	typedef struct packed {
		logic lvl;       // level driven when enabled
		logic oe;        // high while the pin is driven
	} idis_pin_t;

	typedef struct packed {
		logic rd;        // dma read strobe
		logic wr;        // dma write strobe
		logic tc;        // accepted terminal count
	} idis_dma_t;

endpackage

// ===== rtl/idis_irq_drv.sv
// one interrupt pin driver: polarity, enable and float
module idis_irq_drv
	import idis_pkg::*;
(
	// clock and reset
	input  wire logic      clk_i,
	input  wire logic      rstn_i,
	input  wire logic      ce_i,
	// control
	input  wire logic      en_i,
	input  wire logic      act_i,
	input  wire logic      pol_high_i,
	// pin
	output idis_pin_t      pin_o
);

	// ****************************************************************
	// registered pin
	// ****************************************************************
	// asserted level follows polarity; a disabled line floats
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_o <= '0;
		end else if (ce_i) begin
			pin_o.lvl <= pol_high_i ? act_i : ~act_i;
			pin_o.oe  <= en_i;
		end
	end

endmodule

// ===== sim/idis_dmac_model.sv
// partner model: system dma controller that grants floppy and parport requests
module idis_dmac_model
	import idis_pkg::*;
#(
	parameter int XFERS = 3
)(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	// bench control
	input  wire logic [3:0] lag_i,
	input  wire logic       write_i,
	input  wire logic       rogue_i,
	// request pins
	input  idis_pin_t       floppy_req_i,
	input  idis_pin_t       parport_req_i,
	// grant side
	output idis_isa_t       isa_o,
	output logic            floppy_ack_n_o,
	output logic            parport_ack_n_o,
	output logic [7:0]      done_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic       busy_q;
	logic       fdc_q;
	logic [3:0] wait_q;
	logic [7:0] ph_q;
	logic       freq;
	logic       preq;
	logic       last;

	// a floating request pin is not a request
	assign freq = floppy_req_i.oe & floppy_req_i.lvl;
	assign preq = parport_req_i.oe & parport_req_i.lvl;
	assign last = busy_q && (ph_q == 8'(2 * XFERS - 1));

	// grant sequencer: wait lag cycles, then two cycles a transfer
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_q <= 1'b0;
			fdc_q  <= 1'b0;
			wait_q <= 4'h0;
			ph_q   <= 8'h00;
			done_o <= 8'h00;
		end else if (busy_q) begin
			ph_q <= ph_q + 8'h01;
			if (last) begin
				busy_q <= 1'b0;
				done_o <= done_o + 8'h01;
			end
		end else if ((freq | preq) && wait_q >= lag_i) begin
			busy_q <= 1'b1;
			fdc_q  <= freq;
			ph_q   <= 8'h00;
			wait_q <= 4'h0;
		end else if (freq | preq) begin
			wait_q <= wait_q + 4'h1;
		end else begin
			wait_q <= 4'h0;
		end
	end

	// acks pulled high when released; rogue acks without any request
	assign floppy_ack_n_o  = !(rogue_i | (busy_q & fdc_q));
	assign parport_ack_n_o = !(rogue_i | (busy_q & !fdc_q));
	// bus strobes on odd phases, terminal count on the last one
	assign isa_o.aen     = busy_q | rogue_i;
	assign isa_o.iorc_n  = !(rogue_i | (busy_q & ph_q[0] & !write_i));
	assign isa_o.iowc_n  = !(busy_q & ph_q[0] & write_i);
	assign isa_o.tc      = rogue_i | last;
	assign isa_o.hit     = busy_q | rogue_i;
	assign isa_o.ide_hit = 1'b0;
endmodule

// ===== sim/isa_dma_irq_steering_test.sv
// self-checking bench of the dma handshake and irq steering block
module isa_dma_irq_steering_test
	import idis_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int XF = 3;
	logic clk_i, rstn_i, ce_i, psel, pen, pwr, fdc_req, par_req, par_int;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic ready, slverr, fack_n, pack_n, wr_dir, rogue;
	logic [3:0] lag, pend0, pend1;
	logic [7:0] done;
	idis_isa_t isa;
	idis_pin_t zw, freq_p, preq_p, irq3, irq4, irq5, irq7;
	idis_dma_t fdma, pdma;
	int err_total, n_checks, n_rd, n_wr, n_tc, n_zw;
	logic p_rd, p_wr, p_tc;

	idis_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
		.pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
		.pready_o(ready), .pslverr_o(slverr), .isa_i(isa),
		.floppy_dma_ack_n_i(fack_n), .parport_dma_ack_n_i(pack_n),
		.zero_wait_n_o(zw), .fdc_req_i(fdc_req), .par_req_i(par_req),
		.ser0_pend_i(pend0), .ser1_pend_i(pend1), .par_int_i(par_int),
		.floppy_dma_req_o(freq_p), .parport_dma_req_o(preq_p),
		.floppy_dma_o(fdma), .parport_dma_o(pdma), .irq3_o(irq3),
		.irq4_o(irq4), .irq5_o(irq5), .irq7_o(irq7));

	idis_dmac_model #(.XFERS(XF)) dmac (.clk_i(clk_i), .rstn_i(rstn_i),
		.lag_i(lag), .write_i(wr_dir), .rogue_i(rogue),
		.floppy_req_i(freq_p), .parport_req_i(preq_p), .isa_o(isa),
		.floppy_ack_n_o(fack_n), .parport_ack_n_o(pack_n), .done_o(done));

	// ****************************************************************
	// clock, edge counters, watchdog
	// ****************************************************************
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// count strobe and tc rises seen by the units
	always @(posedge clk_i) begin
		if (fdma.rd && !p_rd) n_rd++;
		if (pdma.wr && !p_wr) n_wr++;
		if ((fdma.tc | pdma.tc) && !p_tc) n_tc++;
		if (zw.oe) n_zw++;
		p_rd = fdma.rd;
		p_wr = pdma.wr;
		p_tc = fdma.tc | pdma.tc;
	end

	initial begin
		#100us;
		err_total++;
		give_verdict;
	end

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task give_verdict;
		if (err_total == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task pin(input idis_pin_t seen, input logic oe, input logic lvl);
		chk(32'(seen.oe), 32'(oe));
		if (oe) chk(32'(seen.lvl), 32'(lvl));
	endtask

	// apb transfer: setup, access until pready sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		@(posedge clk_i);
		psel   <= 1'b1;
		pen    <= 1'b0;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (ready === 1'b1) break;
		end
		if (i == 20) chk(32'(ready), 32'h1);
		r = prdata;
		e = slverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		repeat (3) @(posedge clk_i);
	endtask

	function logic [31:0] cfg(input logic [3:0] pol, input logic sw,
		input logic pen7, input logic s04, input logic [1:0] sb,
		input logic [1:0] pb);
		return 32'(pol) | (32'(sw) << SW_CFG_BIT) | (32'(pen7) << PAR_EN_BIT)
			| (32'(s04) << SER0_SEL4_BIT) | (32'(sb) << SER0_BASE_LSB)
			| (32'(pb) << PAR_BASE_LSB);
	endfunction

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_regs;
		logic [31:0] r;
		logic e;
		apb(1'b0, ADDR_DMA_CTRL, 32'h0, r, e);
		chk(r, 32'h0000_0000);
		apb(1'b0, ADDR_IRQ_CFG, 32'h0, r, e);
		chk(r, 32'h0000_000F);
		apb(1'b0, 12'h010, 32'h0, r, e);
		chk({r[30:0], e}, 32'h0000_0001);
	endtask

	task t_floppy;
		fdc_req <= 1'b1;
		wr(ADDR_DMA_CTRL, 32'h0);
		pin(freq_p, 1'b0, 1'b0);
		wr(ADDR_DMA_CTRL, 32'h0000_0008);
		pin(freq_p, 1'b1, 1'b1);
		for (int i = 0; i < 50 && fack_n; i++) @(posedge clk_i);
		fdc_req <= 1'b0;
		for (int i = 0; i < 50 && done != 8'h01; i++) @(posedge clk_i);
		wr(ADDR_DMA_CTRL, 32'h0);
		chk(32'(n_rd), 32'(XF));
		chk(32'(n_tc), 32'h1);
		chk(32'(n_zw), 32'h0);
	endtask

	task t_parport;
		par_req <= 1'b1;
		lag     <= 4'h0;
		wr_dir  <= 1'b1;
		wr(ADDR_DMA_CTRL, 32'h0);
		pin(preq_p, 1'b1, 1'b0);
		wr(ADDR_DMA_CTRL, 32'h0001_0000);
		pin(preq_p, 1'b0, 1'b0);
		wr(ADDR_DMA_CTRL, 32'h0001_0800);
		for (int i = 0; i < 50 && pack_n; i++) @(posedge clk_i);
		par_req <= 1'b0;
		for (int i = 0; i < 50 && done != 8'h02; i++) @(posedge clk_i);
		wr(ADDR_DMA_CTRL, 32'h0);
		chk(32'(n_wr), 32'(XF));
		chk(32'(n_tc), 32'h2);
	endtask

	task t_rogue;
		rogue <= 1'b1;
		wr(ADDR_DMA_CTRL, 32'h0);
		chk(32'(fdma), 32'h0);
		chk(32'(pdma), 32'h0);
		wr(ADDR_DMA_CTRL, 32'h0000_0008);
		chk(32'(fdma), 32'h5);
		rogue <= 1'b0;
	endtask

	task t_serial;
		logic h3;
		pend0 <= 4'h1;
		for (int b = 0; b < 4; b++) begin
			wr(ADDR_SER_CTRL, 32'h0000_0801);
			wr(ADDR_IRQ_CFG, cfg(4'hF, 1'b0, 1'b0, 1'b0, 2'(b), 2'h0));
			h3 = (b == 1 || b == 3);
			pin(irq3, h3, 1'b1);
			pin(irq4, !h3, 1'b1);
		end
		wr(ADDR_IRQ_CFG, cfg(4'h0, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0));
		pin(irq4, 1'b1, 1'b0);
		wr(ADDR_SER_CTRL, 32'h0000_0800);
		pin(irq4, 1'b1, 1'b1);
		wr(ADDR_SER_CTRL, 32'h0000_0001);
		pin(irq4, 1'b0, 1'b0);
		wr(ADDR_SER_CTRL, 32'h0000_0801);
		wr(ADDR_IRQ_CFG, cfg(4'hF, 1'b1, 1'b0, 1'b1, 2'h1, 2'h0));
		pin(irq4, 1'b1, 1'b1);
		pin(irq3, 1'b0, 1'b0);
		wr(ADDR_IRQ_CFG, cfg(4'hF, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0));
		pin(irq3, 1'b1, 1'b1);
		pend1 <= 4'h2;
		wr(ADDR_SER_CTRL, 32'h0802_0000);
		pin(irq3, 1'b1, 1'b1);
		pin(irq4, 1'b0, 1'b0);
	endtask

	task t_parirq;
		par_int <= 1'b1;
		for (int b = 0; b < 3; b++) begin
			wr(ADDR_IRQ_CFG, cfg(4'hF, 1'b0, 1'b1, 1'b0, 2'h0, 2'(b)));
			pin(irq5, b == 1, 1'b1);
			pin(irq7, b != 1, 1'b1);
		end
		wr(ADDR_IRQ_CFG, cfg(4'h3, 1'b1, 1'b1, 1'b0, 2'h0, 2'h0));
		pin(irq5, 1'b1, 1'b0);
		pin(irq7, 1'b0, 1'b0);
		wr(ADDR_IRQ_CFG, cfg(4'hF, 1'b1, 1'b1, 1'b0, 2'h0, 2'h1)
			| (32'h1 << PAR_SEL7_BIT));
		pin(irq7, 1'b1, 1'b1);
		pin(irq5, 1'b0, 1'b0);
		wr(ADDR_IRQ_CFG, cfg(4'hF, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0));
		pin(irq5, 1'b0, 1'b0);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{rstn_i, psel, pen, pwr, fdc_req, par_req, par_int, rogue} = '0;
		{paddr, pwdata, pend0, pend1} = '0;
		ce_i   = 1'b1;
		lag    = 4'h5;
		wr_dir = 1'b0;
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_regs;
		t_floppy;
		t_parport;
		t_serial;
		t_parirq;
		t_rogue;
		give_verdict;
	end
endmodule
